// ===== common/ccdsts_pkg.sv
//------------------------------------------------------------
// ccd shutter / transfer sequencer constants
//------------------------------------------------------------
package ccdsts_pkg;

   localparam int          NPIX         = 8;
   localparam int          CW           = 16;
   localparam int          OW           = 32;
   localparam int          PIX_IDX_W    = 3;
   localparam logic [CW-1:0] FULL_WELL  = 16'h0fa0;
   localparam logic [CW-1:0] CHARGE_RST = 16'h0000;
   localparam logic [OW-1:0] OVF_RST    = 32'h0000_0000;
   localparam logic [3:0]    SHIFT_RST  = 4'h0;

   // line transfer phases, gray along idle -> tg high -> shifting
   typedef enum logic [1:0] {
      CCDSTS_XF_IDLE  = 2'b00,
      CCDSTS_XF_TG_HI = 2'b01,
      CCDSTS_XF_SHIFT = 2'b11
   } ccdsts_xfer_t;

endpackage : ccdsts_pkg

// ===== verilog/ccdsts_hshift.sv
`timescale 1ns/1ps
`default_nettype none
module ccdsts_hshift (
   // clock and reset
   input  wire logic                                        mclk,
   input  wire logic                                        resetn,
   // parallel load and shift
   input  wire logic                                        load,
   input  wire logic [ccdsts_pkg::NPIX*ccdsts_pkg::CW-1:0]  load_data,
   input  wire logic                                        shift,
   // output stage
   output logic      [ccdsts_pkg::CW-1:0]                   rd_data_q,
   output logic                                             rd_strobe_q
);
   import ccdsts_pkg::*;

   logic [NPIX-1:0][CW-1:0] cell_q;

   //------------------------------------------------------------
   // register cells
   //------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cell_q <= '0;
      end else if (load) begin
         cell_q <= load_data;
      end else if (shift) begin
         cell_q <= {cell_q[NPIX-2:0], CHARGE_RST};
      end
   end

   //------------------------------------------------------------
   // output stage
   //------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rd_data_q   <= CHARGE_RST;
         rd_strobe_q <= 1'b0;
      end else begin
         rd_strobe_q <= shift && !load;
         if (shift && !load) begin
            rd_data_q <= cell_q[NPIX-1];
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   AST_HS_LOAD: assert property (load |=> cell_q == $past(load_data))
      else $error("shift register did not take the transfer charge");
   AST_HS_SHIFT: assert property (shift && !load |=> rd_strobe_q
                                  && rd_data_q == $past(cell_q[NPIX-1]))
      else $error("phase clock did not move the last cell to the output");

endmodule : ccdsts_hshift
`default_nettype wire

// ===== verilog/ccdsts_sensor.sv
`timescale 1ns/1ps
`default_nettype none
module ccdsts_sensor (
   // clock and reset
   input  wire logic                                mclk,
   input  wire logic                                resetn,
   // gate drive from the timing generator
   input  wire logic                                shutter_drain_gate,
   input  wire logic                                transfer_gate,
   input  wire logic                                hshift_phase_one,
   input  wire logic                                hshift_phase_two,
   input  wire logic                                slope_gate_far_end,
   input  wire logic                                slope_gate_near_end,
   // incident light, one pixel per cycle
   input  wire logic                                photo_valid,
   input  wire logic [ccdsts_pkg::PIX_IDX_W-1:0]    photo_pixel,
   input  wire logic [ccdsts_pkg::CW-1:0]           photo_charge,
   // readout
   output logic      [ccdsts_pkg::CW-1:0]           video_output,
   output logic                                     video_strobe,
   // status
   output logic      [ccdsts_pkg::OW-1:0]           overflow_drain_charge,
   output logic                                     shutter_open,
   output logic                                     slope_present,
   output logic                                     transfer_fault,
   output logic                                     line_shifting
);
   import ccdsts_pkg::*;

   // clamp to full well
   function automatic logic [CW-1:0] clamp_fw(input logic [CW:0] v);
      clamp_fw = (v > {1'b0, FULL_WELL}) ? FULL_WELL : v[CW-1:0];
   endfunction : clamp_fw

   // part above full well
   function automatic logic [CW:0] excess_fw(input logic [CW:0] v);
      excess_fw = (v > {1'b0, FULL_WELL}) ? (v - {1'b0, FULL_WELL}) : '0;
   endfunction : excess_fw

   logic                    tg_prev_q;
   logic                    p1_prev_q;
   logic                    tg_fall;
   logic                    p1_rise;
   logic                    slope;
   logic                    hs_load;
   logic                    hs_shift;
   logic [NPIX-1:0][CW-1:0] store_lvl;
   logic [NPIX-1:0][CW-1:0] tg_lvl;
   logic [NPIX-1:0][CW:0]   dump;
   logic [OW-1:0]           dump_sum;
   logic [OW-1:0]           ovf_q;
   logic                    fault_q;
   logic [3:0]              shift_cnt_q;
   ccdsts_xfer_t            xfer_q;

   //------------------------------------------------------------
   // gate edge detection
   //------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tg_prev_q <= 1'b0;
         p1_prev_q <= 1'b0;
      end else begin
         tg_prev_q <= transfer_gate;
         p1_prev_q <= hshift_phase_one;
      end
   end

   assign tg_fall  = tg_prev_q && !transfer_gate;
   assign p1_rise  = hshift_phase_one && !p1_prev_q;
   assign slope    = slope_gate_far_end ^ slope_gate_near_end;
   assign hs_load  = tg_fall && hshift_phase_one;
   assign hs_shift = p1_rise && !transfer_gate && (xfer_q == CCDSTS_XF_SHIFT);

   //------------------------------------------------------------
   // per-pixel charge path
   //------------------------------------------------------------
   for (genvar i = 0; i < NPIX; i++) begin : gen_pix
      logic [CW-1:0] reg_q;
      logic [CW-1:0] store_q;
      logic [CW-1:0] tgc_q;
      logic [CW-1:0] inflow;
      logic [CW:0]   to_store;
      logic [CW:0]   sum;
      logic [CW:0]   tg_sum;
      logic [CW:0]   lost;

      assign inflow = (photo_valid && photo_pixel == PIX_IDX_W'(i)) ? photo_charge : CHARGE_RST;

      always_comb begin
         sum    = '0;
         lost   = '0;
         tg_sum = {1'b0, tgc_q};
         // slope moves resistive gate charge into the store each cycle
         to_store = slope ? ({1'b0, reg_q} + {1'b0, inflow}) : '0;
         sum      = {1'b0, store_q} + to_store;
         if (shutter_drain_gate) begin
            lost = sum;
         end else if (transfer_gate) begin
            tg_sum = {1'b0, tgc_q} + sum;
            lost   = excess_fw(tg_sum);
         end else begin
            lost = excess_fw(sum);
         end
         if (tg_fall && !hshift_phase_one) begin
            lost = lost + {1'b0, tgc_q};
         end
      end

      // resistive gate holds charge while no slope exists (pinned)
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            reg_q <= CHARGE_RST;
         end else if (slope) begin
            reg_q <= CHARGE_RST;
         end else begin
            reg_q <= clamp_fw({1'b0, reg_q} + {1'b0, inflow});
         end
      end

      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            store_q <= CHARGE_RST;
         end else if (shutter_drain_gate || transfer_gate) begin
            store_q <= CHARGE_RST;
         end else begin
            store_q <= clamp_fw(sum);
         end
      end

      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            tgc_q <= CHARGE_RST;
         end else if (transfer_gate && !shutter_drain_gate) begin
            tgc_q <= clamp_fw(tg_sum);
         end else if (tg_fall) begin
            tgc_q <= CHARGE_RST;
         end
      end

      assign store_lvl[i] = store_q;
      assign tg_lvl[i]    = tgc_q;
      assign dump[i]      = lost;
   end

   //------------------------------------------------------------
   // overflow drain accounting
   //------------------------------------------------------------
   always_comb begin
      dump_sum = '0;
      for (int k = 0; k < NPIX; k++) begin
         dump_sum = dump_sum + OW'(dump[k]);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ovf_q <= OVF_RST;
      end else begin
         ovf_q <= ovf_q + dump_sum;
      end
   end

   // transfer gate fell without phase one: charge lost, one-cycle flag
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= tg_fall && !hshift_phase_one;
      end
   end

   //------------------------------------------------------------
   // line transfer phase
   //------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         xfer_q      <= CCDSTS_XF_IDLE;
         shift_cnt_q <= SHIFT_RST;
      end else begin
         case (xfer_q)
            CCDSTS_XF_IDLE: begin
               if (transfer_gate) begin
                  xfer_q <= CCDSTS_XF_TG_HI;
               end
            end
            CCDSTS_XF_TG_HI: begin
               if (hs_load) begin
                  xfer_q      <= CCDSTS_XF_SHIFT;
                  shift_cnt_q <= SHIFT_RST;
               end else if (tg_fall) begin
                  xfer_q <= CCDSTS_XF_IDLE;
               end
            end
            CCDSTS_XF_SHIFT: begin
               if (transfer_gate) begin
                  xfer_q <= CCDSTS_XF_TG_HI;
               end else if (hs_shift) begin
                  shift_cnt_q <= shift_cnt_q + 4'h1;
                  if (shift_cnt_q == 4'(NPIX - 1)) begin
                     xfer_q <= CCDSTS_XF_IDLE;
                  end
               end
            end
            default: begin
               xfer_q <= CCDSTS_XF_IDLE;
            end
         endcase
      end
   end

   ccdsts_hshift u_hshift (
      .mclk        (mclk),
      .resetn      (resetn),
      .load        (hs_load),
      .load_data   (tg_lvl),
      .shift       (hs_shift),
      .rd_data_q   (video_output),
      .rd_strobe_q (video_strobe)
   );

   assign overflow_drain_charge = ovf_q;
   assign shutter_open          = !shutter_drain_gate;
   assign slope_present         = slope;
   assign transfer_fault        = fault_q;
   assign line_shifting         = (xfer_q == CCDSTS_XF_SHIFT);

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   AST_OPEN_COLLECTS: assert property (!shutter_drain_gate && !transfer_gate
                                       |=> store_lvl[0] >= $past(store_lvl[0]))
      else $error("store gate lost charge while shutter open");
   AST_FULL_WELL: assert property (store_lvl[0] <= FULL_WELL)
      else $error("store gate above full well");
   AST_SPILL: assert property (!shutter_drain_gate && !transfer_gate && !tg_fall
                               && dump[0] != '0 |=> store_lvl[0] == FULL_WELL)
      else $error("spill without full store gate");
   AST_SWEEP: assert property (shutter_drain_gate |=> store_lvl[0] == CHARGE_RST)
      else $error("store gate kept charge while shutter closed");
   AST_DISCARD: assert property (shutter_drain_gate && transfer_gate
                                 |=> tg_lvl[0] == $past(tg_lvl[0]))
      else $error("closed-shutter charge reached the transfer gate");
   AST_TG_TAKES: assert property (transfer_gate && !shutter_drain_gate
                                  |=> store_lvl[0] == CHARGE_RST)
      else $error("store gate not emptied under transfer gate");
   AST_TG_EMPTIES: assert property (hs_load |=> tg_lvl[0] == CHARGE_RST && line_shifting)
      else $error("transfer gate charge not handed on");
   AST_SHIFT_RUN: assert property (hs_shift |=> video_strobe)
      else $error("phase clock produced no output sample");
   AST_WINDOW: assert property (transfer_gate && !shutter_drain_gate && slope
                                && photo_valid && photo_pixel == '0 && photo_charge != '0
                                && tg_lvl[0] < FULL_WELL
                                |=> tg_lvl[0] > $past(tg_lvl[0]))
      else $error("charge during transfer not included");

   COV_LINE: cover property (hs_load ##[1:200] video_strobe);
   COV_SWEEP: cover property (shutter_drain_gate ##1 !shutter_drain_gate [*4] ##1 transfer_gate);
   COV_PINNED: cover property (!slope [*4] ##1 slope ##[1:20] transfer_gate);
   COV_FAULT: cover property (transfer_fault);
   COV_PHASE_TWO: cover property (line_shifting && hshift_phase_two);

endmodule : ccdsts_sensor
`default_nettype wire

// ===== test/ccdsts_tgen.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// timing generator model
// ----
module ccdsts_tgen (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // line control
   input  wire logic       start,
   input  wire logic       shutter_en,
   input  wire logic       pinned_mode,
   input  wire logic       align_tg,
   input  wire logic       drain_req,
   input  wire logic       skip_p1,
   input  wire logic [3:0] tg_len,
   input  wire logic [4:0] npulse,
   // gate drive and line status
   output logic            drain,
   output logic            tg,
   output logic            p1,
   output logic            p2,
   output logic            far_end,
   output logic            near_end,
   output logic            busy,
   output int              integ_cycles
);
   logic slope_on;
   int   now;
   int   fall_at;
   assign drain    = shutter_en & drain_req;
   assign far_end  = !pinned_mode | slope_on;
   assign near_end = 1'b0;
   always @(posedge mclk) now <= now + 1;
   always @(negedge drain) fall_at = now;
   task run_line;
      busy <= 1'b1;
      if (pinned_mode && !align_tg) begin
         slope_on <= 1'b1;
         @(posedge mclk);
      end
      tg       <= 1'b1;
      slope_on <= 1'b1;
      repeat (tg_len) @(posedge mclk);
      p1 <= !skip_p1;
      @(posedge mclk);
      tg           <= 1'b0;
      integ_cycles <= now - fall_at;
      @(posedge mclk);
      slope_on <= 1'b0;
      if (!skip_p1) begin
         repeat (npulse) begin
            p1 <= 1'b0;
            @(posedge mclk);
            p2 <= 1'b1;
            @(posedge mclk);
            p2 <= 1'b0;
            @(posedge mclk);
            p1 <= 1'b1;
            @(posedge mclk);
         end
      end
      p1   <= 1'b0;
      busy <= 1'b0;
   endtask : run_line
   initial begin
      {tg, p1, p2, slope_on, busy} = '0;
      integ_cycles = 0;
      now = 0;
      fall_at = 0;
      forever begin
         @(posedge mclk);
         if (resetn && start && !busy) run_line();
      end
   end
endmodule : ccdsts_tgen
`default_nettype wire

// ===== test/ccdsts_sensor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ccdsts_sensor_tb;
   import ccdsts_pkg::*;
   logic mclk, resetn, photo_valid, start, shutter_en, pinned_mode, align_tg, drain_req;
   logic skip_p1, busy, video_strobe, shutter_open, slope_present, transfer_fault;
   logic shutter_drain_gate, transfer_gate, hshift_phase_one, hshift_phase_two;
   logic slope_gate_far_end, slope_gate_near_end, line_shifting;
   logic [2:0]  photo_pixel;
   logic [3:0]  tg_len;
   logic [4:0]  npulse;
   logic [15:0] photo_charge, video_output;
   logic [31:0] overflow_drain_charge, exp_ovf;
   logic [15:0] got_q[$];
   int          exp_store[NPIX], exp_held[NPIX], num_errors, total_checks;
   bit          fault_seen, shift_seen;
   ccdsts_sensor i_ccdsts_sensor (.mclk, .resetn, .shutter_drain_gate, .transfer_gate,
      .hshift_phase_one, .hshift_phase_two, .slope_gate_far_end, .slope_gate_near_end,
      .photo_valid, .photo_pixel, .photo_charge, .video_output, .video_strobe,
      .overflow_drain_charge, .shutter_open, .slope_present, .transfer_fault, .line_shifting);
   ccdsts_tgen i_ccdsts_tgen (.mclk, .resetn, .start, .shutter_en, .pinned_mode, .align_tg,
      .drain_req, .skip_p1, .tg_len, .npulse, .drain(shutter_drain_gate), .tg(transfer_gate),
      .p1(hshift_phase_one), .p2(hshift_phase_two), .far_end(slope_gate_far_end),
      .near_end(slope_gate_near_end), .busy, .integ_cycles());
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic check_val(string n, logic [31:0] got, logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", n, exp, got);
      end
   endtask : check_val
   task automatic check_bit(string n, logic got, logic exp);
      check_val(n, {31'h0, got}, {31'h0, exp});
   endtask : check_bit
   function automatic void absorb(int px, int q);
      int s;
      s = exp_store[px] + q;
      if (s > FULL_WELL) begin
         exp_ovf += s - FULL_WELL;
         s = FULL_WELL;
      end
      exp_store[px] = s;
   endfunction : absorb
   always @(posedge mclk) begin
      if (video_strobe === 1'b1) got_q.push_back(video_output);
      if (transfer_fault === 1'b1) fault_seen = 1'b1;
      if (line_shifting === 1'b1) shift_seen = 1'b1;
      if (resetn === 1'b1) begin
         check_bit("shutter_open", shutter_open, !shutter_drain_gate);
         check_bit("slope_present", slope_present, slope_gate_far_end ^ slope_gate_near_end);
      end
   end
   task automatic setup(bit pin, bit al, bit sh, bit dr, int tl);
      @(posedge mclk);
      pinned_mode <= pin;
      align_tg    <= al;
      shutter_en  <= sh;
      drain_req   <= dr;
      tg_len      <= tl[3:0];
      @(posedge mclk);
   endtask : setup
   task automatic light(int n, int qmax, bit corner);
      int px, q;
      repeat (n) begin
         @(posedge mclk);
         px = corner ? 0 : $urandom_range(NPIX - 1);
         q  = corner ? qmax : $urandom_range(qmax);
         photo_valid  <= 1'b1;
         photo_pixel  <= px[2:0];
         photo_charge <= q[15:0];
         if (shutter_drain_gate) exp_ovf += q;
         else if (slope_gate_far_end !== slope_gate_near_end) absorb(px, q);
         else exp_held[px] += q;
      end
      @(posedge mclk);
      photo_valid <= 1'b0;
   endtask : light
   task automatic run_line(int npl, bit fault, string name);
      int k, q;
      bit lit;
      for (k = 0; k < NPIX; k++) begin
         absorb(k, exp_held[k]);
         exp_held[k] = 0;
      end
      got_q.delete();
      fault_seen = 1'b0;
      shift_seen = 1'b0;
      lit        = 1'b0;
      @(posedge mclk);
      npulse  <= npl[4:0];
      skip_p1 <= fault;
      start   <= 1'b1;
      @(posedge mclk);
      start <= 1'b0;
      k = 0;
      @(posedge mclk);
      while (busy === 1'b1 && k < 600) begin
         if (transfer_gate === 1'b1 && !lit) begin
            q = $urandom_range(16'h0400, 1);
            photo_valid  <= 1'b1;
            photo_pixel  <= 3'h0;
            photo_charge <= q[15:0];
            absorb(0, q);
            lit = 1'b1;
         end else begin
            photo_valid <= 1'b0;
         end
         @(posedge mclk);
         k++;
      end
      if (k >= 600) num_errors++;
      repeat (4) @(posedge mclk);
      check_bit("transfer_fault", fault_seen, fault);
      check_val("strobe_count", 32'(got_q.size()),
                fault ? 0 : 32'(npl < NPIX ? npl : NPIX));
      if (fault) begin
         for (k = 0; k < NPIX; k++) exp_ovf += exp_store[k];
      end else begin
         check_bit("line_shifting", shift_seen, 1'b1);
         for (k = 0; k < npl && k < got_q.size(); k++) begin
            check_val("video_output", got_q[k], k < NPIX ? exp_store[NPIX-1-k] : 0);
         end
      end
      for (k = 0; k < NPIX; k++) exp_store[k] = 0;
      check_val("overflow_drain_charge", overflow_drain_charge, exp_ovf);
      $display("test %s done", name);
   endtask : run_line
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      finish_test();
   end
   initial begin
      int k;
      {resetn, photo_valid, start, shutter_en, pinned_mode, align_tg, drain_req} = '0;
      {photo_pixel, photo_charge, skip_p1} = '0;
      tg_len = 4'h1;
      npulse = 5'h08;
      exp_ovf = '0;
      void'($urandom(65));
      repeat (6) @(posedge mclk);
      check_val("video_output", video_output, 0);
      check_val("overflow_drain_charge", overflow_drain_charge, 0);
      check_bit("line_shifting", line_shifting, 1'b0);
      resetn <= 1'b1;
      setup(1'b0, 1'b0, 1'b1, 1'b1, 3);
      light(6, 16'h0800, 1'b0);
      setup(1'b0, 1'b0, 1'b1, 1'b0, 3);
      light(3, 16'h0800, 1'b1);
      light(12, 16'h0800, 1'b0);
      run_line(10, 1'b0, "shutter");
      setup(1'b0, 1'b0, 1'b0, 1'b1, 1);
      light(8, 16'h0800, 1'b0);
      run_line(8, 1'b0, "no shutter");
      setup(1'b1, 1'b0, 1'b1, 1'b1, 2);
      setup(1'b1, 1'b0, 1'b1, 1'b0, 2);
      light(12, 16'h0100, 1'b0);
      run_line(9, 1'b0, "pinned early slope");
      setup(1'b1, 1'b1, 1'b1, 1'b0, 5);
      run_line(8, 1'b0, "pinned aligned slope");
      repeat (3) begin
         k = $urandom_range(1);
         setup(k[0], 1'b0, 1'b1, 1'b0, $urandom_range(8, 1));
         light($urandom_range(12, 4), k ? 16'h0100 : 16'h0800, 1'b0);
         run_line($urandom_range(12, 8), 1'b0, "random line");
      end
      setup(1'b0, 1'b0, 1'b1, 1'b0, 2);
      light(8, 16'h0800, 1'b0);
      run_line(8, 1'b1, "transfer without phase one");
      finish_test();
   end
endmodule : ccdsts_sensor_tb
`default_nettype wire
